// [core/pin_unit_pkg.sv]
// Package with register map, field layout and decoded carrier types.
`default_nettype none
package pin_unit_pkg;
	// ****************************************************************
	// Register map and reset values
	// ****************************************************************
	localparam logic [3:0] PIN_CFG_OFFSET  = 4'h0;
	localparam logic [3:0] ACQ_CFG_OFFSET  = 4'h4;
	localparam logic [3:0] PIN_STAT_OFFSET = 4'h8;
	localparam logic [3:0] ACQ_STAT_OFFSET = 4'hc;
	localparam logic [7:0] PIN_CFG_RESET   = 8'h00;
	localparam logic [7:0] ACQ_CFG_RESET   = 8'h05;
	localparam logic [7:0] ACQ_WRITE_MASK  = 8'h1f;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int FXN_LSB       = 0;
	localparam int OPT_LSB       = 2;
	localparam int OPT_POL       = 5;
	localparam int OPT_RAIL      = 3;
	localparam int OPT_PULLUP    = 2;
	localparam int OPT_DRIVE_HI  = 1;
	localparam int OPT_PULLDOWN  = 0;
	localparam int ACQ_AMPS_LSB  = 0;
	localparam int ACQ_VOLTS_BIT = 2;
	localparam int ACQ_TCELL_BIT = 3;
	localparam int ACQ_TFET_BIT  = 4;
	localparam logic [15:0] MV_SATURATION = 16'h7fff;

	// Pin function encodings.
	typedef enum logic [1:0] {
		FXN_UNUSED = 2'b00,
		FXN_GPO    = 2'b01,
		FXN_DRIVER = 2'b10,
		FXN_ANALOG = 2'b11
	} pin_function_t;

	// Decoded pin controls for the pad and the measurement subsystem.
	typedef struct packed {
		logic       out_enable;
		logic       level;
		logic       drive_hi_en;
		logic       rail_first_reg;
		logic       weak_pullup;
		logic       weak_pulldown;
		logic       analog_en;
		logic [1:0] analog_pullup;
		logic [1:0] temp_model;
		logic [1:0] meas_use;
	} pin_ctrl_t;

	// Decoded acquisition controls.
	typedef struct packed {
		logic       tint_cell;
		logic       tint_fet;
		logic       tint_in_stats;
		logic       volts_cv;
		logic [1:0] amps_unit;
	} acq_ctrl_t;
endpackage
`default_nettype wire

// [core/pin_and_unit_config.sv]
// Discharge-driver pin setting and acquisition unit setting register bank.
//
// Contract
// - Function field picks unused, general output, discharge driver or analog.
// - Option meaning depends on function; all pin bits reset to zero.
// - Driver mode: option 5 picks polarity of pin while FET disabled.
// - Polarity ignored for general output; option 4 unused in outputs.
// - Option 3 picks high-drive rail: 1.8 V rail or first rail.
// - Option 2 enables weak pull-up to first rail; code masks it off while option 3 is set.
// - Option 1 drives high or tri-states; tri-state unavailable with option 3.
// - Option 0 enables weak pull-down to ground.
// - Analog mode: options 5:4 select 18k, 180k or no pull-up.
// - Analog mode: options 3:2 select temperature model or raw counts.
// - Analog mode: options 1:0 select general, cell, report or FET use.
// - Acquisition bit 3 uses internal temperature as a cell temperature.
// - Acquisition bit 4 routes it to FET temperature only with bit 3.
// - Internal temperature as FET temperature leaves cell statistics.
// - Acquisition bit 2 picks 1 mV or 10 mV voltage unit, default 10 mV.
// - Millivolt voltages saturate at 32767; software picks units accordingly.
// - Acquisition bits 1:0 pick current unit 0.1 to 100 mA, default 1.
//
// Local design decisions: register access over Wishbone and the register offsets.
`default_nettype none
module pin_and_unit_config (
	// Clock and reset.
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Classic Wishbone slave.
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	input  wire logic                    we_i,
	input  wire logic [3:0]              adr_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic [31:0]             dat_i,
	output logic      [31:0]             dat_o,
	output logic                         ack_o,
	output logic                         err_o,
	// Pin driver and measurement side.
	input  wire logic                    fet_enabled_i,
	input  wire logic                    gpo_level_i,
	input  wire logic signed [19:0]      volt_raw_mv_i,
	output pin_unit_pkg::pin_ctrl_t      pin_ctrl_o,
	output pin_unit_pkg::acq_ctrl_t      acq_ctrl_o,
	output logic signed [15:0]           volt_report_o
);
	import pin_unit_pkg::*;

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [7:0]        pin_cfg_q;
	logic [7:0]        acq_cfg_q;
	logic              ack_q;
	logic              err_q;
	logic [31:0]       dat_q;
	pin_ctrl_t         pin_ctrl_q;
	acq_ctrl_t         acq_ctrl_q;
	logic signed [15:0] volt_q;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	// A request is served once; ack falls the cycle after it is given.
	wire        req      = cyc_i & stb_i & ~ack_q & ~err_q;
	wire        hit_pin  = adr_i == PIN_CFG_OFFSET;
	wire        hit_acq  = adr_i == ACQ_CFG_OFFSET;
	wire        hit_ps   = adr_i == PIN_STAT_OFFSET;
	wire        hit_as   = adr_i == ACQ_STAT_OFFSET;
	wire        mapped   = hit_pin | hit_acq | hit_ps | hit_as;
	wire        wr_lane0 = req & we_i & sel_i[0];
	wire        wr_pin   = wr_lane0 & hit_pin;
	wire        wr_acq   = wr_lane0 & hit_acq;

	// Read mux; status words show the decoded pin and acquisition state.
	wire [31:0] rd_data =
		hit_pin ? {24'h000000, pin_cfg_q} :
		hit_acq ? {24'h000000, acq_cfg_q} :
		hit_ps  ? {19'h00000, pin_ctrl_q} :
		hit_as  ? {26'h0000000, acq_ctrl_q} : 32'h00000000;

	// ****************************************************************
	// Pin decode
	// ****************************************************************
	wire [1:0] fxn     = pin_cfg_q[FXN_LSB +: 2];
	wire [5:0] opt     = pin_cfg_q[OPT_LSB +: 6];
	wire       is_gpo  = fxn == FXN_GPO;
	wire       is_drv  = fxn == FXN_DRIVER;
	wire       is_out  = is_gpo | is_drv;
	wire       is_adc  = fxn == FXN_ANALOG;
	// Driver level: high while FET is off unless polarity inverts it.
	wire       drv_lvl = fet_enabled_i ^ ~opt[OPT_POL];
	// General output follows its command; polarity plays no part.
	wire       out_lvl = is_drv ? drv_lvl : gpo_level_i;
	// Tri-state high only when the low-voltage rail is chosen.
	wire       hi_drv  = opt[OPT_DRIVE_HI] | opt[OPT_RAIL];

	pin_ctrl_t pin_ctrl_d;
	always_comb begin
		pin_ctrl_d                = '0;
		pin_ctrl_d.out_enable     = is_out;
		pin_ctrl_d.level          = is_out & out_lvl;
		pin_ctrl_d.drive_hi_en    = is_out & hi_drv;
		pin_ctrl_d.rail_first_reg = is_out & opt[OPT_RAIL];
		// Pull-up is masked with the first rail to protect the pad.
		pin_ctrl_d.weak_pullup    = is_out & opt[OPT_PULLUP]
			& ~opt[OPT_RAIL];
		pin_ctrl_d.weak_pulldown  = is_out & opt[OPT_PULLDOWN];
		pin_ctrl_d.analog_en      = is_adc;
		pin_ctrl_d.analog_pullup  = is_adc ? opt[5:4] : 2'b00;
		pin_ctrl_d.temp_model     = is_adc ? opt[3:2] : 2'b00;
		pin_ctrl_d.meas_use       = is_adc ? opt[1:0] : 2'b00;
	end

	// ****************************************************************
	// Acquisition decode
	// ****************************************************************
	wire tcell = acq_cfg_q[ACQ_TCELL_BIT];
	wire tfet  = tcell & acq_cfg_q[ACQ_TFET_BIT];

	acq_ctrl_t acq_ctrl_d;
	always_comb begin
		acq_ctrl_d               = '0;
		acq_ctrl_d.tint_cell     = tcell;
		acq_ctrl_d.tint_fet      = tfet;
		acq_ctrl_d.tint_in_stats = tcell & ~tfet;
		acq_ctrl_d.volts_cv      = acq_cfg_q[ACQ_VOLTS_BIT];
		acq_ctrl_d.amps_unit     = acq_cfg_q[ACQ_AMPS_LSB +: 2];
	end

	// ****************************************************************
	// Voltage scaling
	// ****************************************************************
	// Divide by ten for centivolts, then clamp into a signed 16-bit word.
	wire signed [19:0] v_cv  = volt_raw_mv_i / 20'sd10;
	wire signed [19:0] v_sel = acq_cfg_q[ACQ_VOLTS_BIT] ? v_cv
		: volt_raw_mv_i;
	wire               v_hi  = v_sel > 20'sd32767;
	wire               v_lo  = v_sel < -20'sd32768;
	wire signed [15:0] v_sat = v_hi ? MV_SATURATION :
		v_lo ? 16'sh8000 : v_sel[15:0];

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Configuration storage; bits 7:5 of acquisition stay zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_cfg_q <= PIN_CFG_RESET;
			acq_cfg_q <= ACQ_CFG_RESET;
		end else begin
			if (wr_pin)
				pin_cfg_q <= dat_i[7:0];
			if (wr_acq)
				acq_cfg_q <= dat_i[7:0] & ACQ_WRITE_MASK;
		end
	end

	// Bus answer: ack one cycle after the request, error for holes.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= req & mapped;
			err_q <= req & ~mapped;
			dat_q <= (req & ~we_i) ? rd_data : 32'h00000000;
		end
	end

	// Registered outputs to the pad and measurement logic.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_ctrl_q <= '0;
			acq_ctrl_q <= '0;
			volt_q     <= 16'sh0000;
		end else begin
			pin_ctrl_q <= pin_ctrl_d;
			acq_ctrl_q <= acq_ctrl_d;
			volt_q     <= v_sat;
		end
	end

	assign ack_o         = ack_q;
	assign err_o         = err_q;
	assign dat_o         = dat_q;
	assign pin_ctrl_o    = pin_ctrl_q;
	assign acq_ctrl_o    = acq_ctrl_q;
	assign volt_report_o = volt_q;
endmodule
`default_nettype wire

// [dv/pin_and_unit_config_chk.sv]
// Port-level assertions for the pin and unit configuration bank.
`default_nettype none
module pin_and_unit_chk (
	// Clock, reset and bus.
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      cyc_i,
	input wire logic                      stb_i,
	input wire logic [3:0]                adr_i,
	input wire logic [31:0]               dat_o,
	input wire logic                      ack_o,
	input wire logic                      err_o,
	// Pin and measurement side.
	input wire logic signed [19:0]        volt_raw_mv_i,
	input wire pin_unit_pkg::pin_ctrl_t   pin_ctrl_o,
	input wire pin_unit_pkg::acq_ctrl_t   acq_ctrl_o,
	input wire logic signed [15:0]        volt_report_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import pin_unit_pkg::*;
	// All checks sample on the rising edge and rest during reset.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence taken_s; cyc_i && stb_i && !ack_o && !err_o; endsequence
	sequence answer_s; (ack_o ^ err_o) ##1 !(ack_o || err_o); endsequence
	bus_answer_a:
		assert property (taken_s |=> answer_s) else $error("bus answer");
	addr_map_a:
		assert property ((ack_o || err_o) |-> err_o == ($past(adr_i[1:0]) != 0))
		else $error("ack or err wrong for address");
	read_idle_a:
		assert property (!ack_o |-> dat_o == 32'h0) else $error("read idle");
	rsvd_zero_a:
		assert property (ack_o && $past(adr_i) == ACQ_CFG_OFFSET |->
			dat_o[31:5] == 27'h0) else $error("reserved bits not zero");
	fet_route_a:
		assert property (acq_ctrl_o.tint_fet |-> acq_ctrl_o.tint_cell &&
			!acq_ctrl_o.tint_in_stats) else $error("fet temperature routing");
	cell_stats_a:
		assert property (acq_ctrl_o.tint_cell && !acq_ctrl_o.tint_fet |->
			acq_ctrl_o.tint_in_stats) else $error("cell temperature use");
	rail_guard_a:
		assert property (pin_ctrl_o.rail_first_reg |-> pin_ctrl_o.drive_hi_en &&
			!pin_ctrl_o.weak_pullup) else $error("first rail guard");
	mv_sat_a:
		assert property (volt_raw_mv_i > 20'sd32767 |=> acq_ctrl_o.volts_cv ||
			volt_report_o == 16'sh7fff) else $error("millivolt saturation");
endmodule
bind pin_and_unit_config pin_and_unit_chk chk (.clk_i, .rst_i, .cyc_i,
	.stb_i, .adr_i, .dat_o, .ack_o, .err_o, .volt_raw_mv_i, .pin_ctrl_o,
	.acq_ctrl_o, .volt_report_o);
`default_nettype wire

// [dv/tb_pin_and_unit_config.sv]
// Self-checking bench for the pin and unit configuration bank.
`default_nettype none
`define CHK(n, x, g) begin total_checks++; if ((g) !== (x)) begin \
	err_count++; $display("BAD %s exp %0h got %0h", n, x, g); end end
module tb_pin_and_unit_config;
	timeunit 1ns;
	timeprecision 1ns;
	import pin_unit_pkg::*;
	logic               clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic               fet_enabled_i = 0, gpo_level_i = 0, ack_o, err_o, e;
	logic [3:0]         adr_i = 0;
	logic [31:0]        dat_i = 0, dat_o, r;
	logic signed [19:0] volt_raw_mv_i = 0;
	logic signed [15:0] volt_report_o;
	pin_ctrl_t          pin_ctrl_o;
	acq_ctrl_t          acq_ctrl_o;
	int                 err_count = 0, total_checks = 0, cycles = 0;
	// Pin cases: setting, fet and output command, field mask, fields.
	logic [43:0]        pc [12] = '{
		44'h81_1_1800_1800, 44'h81_2_0800_0000,
		44'h02_0_1800_1800, 44'h02_2_0800_0000,
		44'h82_0_0800_0000, 44'h21_0_0600_0600,
		44'h31_0_0300_0200, 44'h11_0_0700_0100,
		44'h09_0_0400_0400, 44'h45_0_1fff_1080,
		44'hb7_0_1fff_006d, 44'h00_0_1fff_0000};
	// Device under test; only byte lane zero carries data.
	pin_and_unit_config uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i(4'hf), .dat_i, .dat_o, .ack_o, .err_o, .fet_enabled_i,
		.gpo_level_i, .volt_raw_mv_i, .pin_ctrl_o, .acq_ctrl_o, .volt_report_o);
	// Free-running 25 MHz clock.
	initial forever #20 clk_i = ~clk_i;
	// Cuts a hung run short well past the expected length.
	always @(posedge clk_i) if (++cycles == 3000) conclude(1);
	// One classic cycle; data and error are taken at the edge that sees ack.
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (!(ack_o || err_o));
		r = dat_o;
		e = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// Reset values, masked acquisition bits and an unmapped address.
	task automatic test_regs;
		wb(1'b0, PIN_CFG_OFFSET, 8'h00);
		`CHK("pin reset", 32'h0, r)
		wb(1'b0, PIN_STAT_OFFSET, 8'h00);
		`CHK("pin status", 32'h0, r)
		wb(1'b0, ACQ_CFG_OFFSET, 8'h00);
		`CHK("acq reset", 32'h5, r)
		wb(1'b1, ACQ_CFG_OFFSET, 8'hff);
		wb(1'b0, ACQ_CFG_OFFSET, 8'h00);
		`CHK("acq readback", 32'h1f, r)
		`CHK("acq decode", 6'h37, acq_ctrl_o)
		wb(1'b0, ACQ_STAT_OFFSET, 8'h00);
		`CHK("acq status", 32'h37, r)
		wb(1'b0, 4'h6, 8'h00);
		`CHK("unmapped", 1'b1, e)
	endtask
	// Each pin case sets the inputs, writes the setting, compares fields.
	task automatic test_pin;
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_i);
			{fet_enabled_i, gpo_level_i} <= pc[i][33:32];
			wb(1'b1, PIN_CFG_OFFSET, pc[i][43:36]);
			repeat (2) @(negedge clk_i);
			`CHK("pin", pc[i][12:0], pin_ctrl_o & pc[i][28:16])
		end
	endtask
	// Writes an acquisition setting and a raw voltage, checks both outputs.
	task automatic vchk(input logic [7:0] c, input logic signed [19:0] v,
		input logic [5:0] xa, input logic signed [15:0] xv);
		wb(1'b1, ACQ_CFG_OFFSET, c);
		@(posedge clk_i);
		volt_raw_mv_i <= v;
		repeat (2) @(negedge clk_i);
		`CHK("acq", xa, acq_ctrl_o)
		`CHK("volt", xv, volt_report_o)
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic conclude(input int hung);
		err_count += hung;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Holds reset for six cycles, then runs the scenarios.
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		test_regs;
		test_pin;
		vchk(8'h10, 20'sd40000, 6'h00, 16'sh7fff);
		vchk(8'h09, -20'sd1234, 6'h29, -16'sd1234);
		vchk(8'h0e, 20'sd123459, 6'h2e, 16'sd12345);
		vchk(8'h07, -20'sd999, 6'h07, -16'sd99);
		conclude(0);
	end
endmodule
`default_nettype wire
